// [core/ccr_params.svh]
// Constants of the codec control register bank: register keys, reset values, field positions, timing.
// Assumes inclusion by the bank module only.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register keys: bank select in bit 4, location in bits 3..0
// ----------------------------------------------------------------------------
`define CCR_KEY_DIGITAL_CONTROL 5'h00
`define CCR_KEY_ANALOGUE_CONTROL 5'h01
`define CCR_KEY_ANALOGUE_GAIN 5'h02
`define CCR_KEY_TX_DIGITAL_GAIN 5'h03
`define CCR_KEY_SIDETONE_GAIN 5'h05
`define CCR_KEY_RX_DIGITAL_GAIN 5'h07
`define CCR_KEY_TONE_CONTROL 5'h10
`define CCR_KEY_SEQ_STEPS_LOW 5'h11
`define CCR_KEY_SEQ_STEPS_HIGH 5'h12

// ----------------------------------------------------------------------------
// Address byte fields
// ----------------------------------------------------------------------------
`define CCR_ADDR_READ_BIT 7
`define CCR_ADDR_BANK_BIT 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCR_RST_DIGITAL_CONTROL 8'h00
`define CCR_RST_ANALOGUE_CONTROL 8'h00
`define CCR_RST_ANALOGUE_GAIN 8'h08
`define CCR_RST_TX_DIGITAL_GAIN 8'h6d
`define CCR_RST_SIDETONE_GAIN 8'h20
`define CCR_RST_RX_DIGITAL_GAIN 8'h5b
`define CCR_RST_TONE_CONTROL 8'h00
`define CCR_RST_SEQ_STEPS 8'h00

// ----------------------------------------------------------------------------
// Writable masks (bits outside read back as zero, except the live overload flags in analogue control)
// ----------------------------------------------------------------------------
`define CCR_MASK_DIGITAL_CONTROL 8'hfe
`define CCR_MASK_ANALOGUE_CONTROL 8'h27
`define CCR_MASK_ANALOGUE_GAIN 8'h7f
`define CCR_MASK_SEQ_STEPS 8'h3f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCR_DC_ALAW 7
`define CCR_DC_RXEN 6
`define CCR_DC_TXEN 5
`define CCR_DC_DIV_HI 4
`define CCR_DC_DIV_LO 1
`define CCR_AC_LOOP 5
`define CCR_AC_RXCLIP 4
`define CCR_AC_TXCLIP 3
`define CCR_AC_EP 2
`define CCR_AC_SPK 1
`define CCR_AC_NOV 0
`define CCR_AG_MICB 6
`define CCR_AG_MICA 5
`define CCR_AG_MICGAIN_HI 4
`define CCR_AG_MICGAIN_LO 2
`define CCR_AG_EPGAIN_HI 1
`define CCR_AG_EPGAIN_LO 0
`define CCR_TC_RING 7
`define CCR_TC_RX_TONE_INJECT 6
`define CCR_TC_TX_TONE_INJECT 5
`define CCR_TC_SLOW 4
`define CCR_TC_BURST 3
`define CCR_TC_SQUARE 2
`define CCR_TC_DUAL 1
`define CCR_TC_START 0

// ----------------------------------------------------------------------------
// PCM word lengths and timing
// ----------------------------------------------------------------------------
`define CCR_PCM_LINEAR_BITS 5'd16
`define CCR_PCM_ALAW_BITS 5'd8
`define CCR_CLK_PERIOD_NS 40
`define CCR_CAD_STEP_FAST_MS 1
`define CCR_CAD_STEP_SLOW_MS 4
`define CCR_NS_PER_MS 1000000
`define CCR_MS_CYCLES (`CCR_NS_PER_MS / `CCR_CLK_PERIOD_NS)

`endif

// [core/ccr_pkg.sv]
// Types of the codec control register bank: codec control and tone control bundles, sequencer states.
// Assumes the constants header is compiled alongside.
package ccr_pkg;

  // --------------------------------------------------------------------------
  // Control bundle towards the codec datapath and analogue front end
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pcmALaw;
    logic [4:0] pcmWordBits;
    logic rxChannelOn;
    logic txChannelOn;
    logic dividerOn;
    logic loopback;
    logic earpieceOn;
    logic speakerOn;
    logic voiceMute;
    logic micAConnect;
    logic micBConnect;
    logic [2:0] micAmpGain;
    logic [1:0] earpieceAmpGain;
    logic [7:0] txDigitalGainCoeff;
    logic [7:0] sidetoneCoeff;
    logic sidetoneOn;
    logic [7:0] rxDigitalGainCoeff;
  } ccr_ctrl_t;

  // --------------------------------------------------------------------------
  // Tone generator control bundle
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rxInject;
    logic txInject;
    logic squareWave;
    logic dualTone;
    logic burst;
    logic running;
    logic gate;
    logic [1:0] stepCode;
    logic [2:0] stepIndex;
  } ccr_tone_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ON = 3'b010,
    SEQ_OFF = 3'b100
  } ccr_seq_state_t;

endpackage

// [core/ccr_register_bank.sv]
// Codec control register bank with its serial control port and tone step sequencer.
// Assumes the serial port pins are asynchronous to clock; overload flags and tone signals are on clock.
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_register_bank
  import ccr_pkg::*;
#(
  parameter int MS_CYCLES = `CCR_MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial control port pins
  input wire logic ctrlSelect_n,
  input wire logic ctrlShiftClk,
  input wire logic ctrlDataIn,
  output logic ctrlDataOut,
  output logic ctrlDataOutEn,
  // Status from the channels
  input wire logic rxOverload,
  input wire logic txOverload,
  // Tone generator interface
  input wire logic [7:0] cadencePeriod,
  input wire logic [7:0] cadenceOnTime,
  input wire logic toneWave,
  // Master clock divider
  output logic dividedClkTick,
  // Controls
  output ccr_ctrl_t codecCtrl,
  output ccr_tone_t toneCtrl,
  // Tone ringer pins
  output logic ringerPosOut,
  output logic ringerPosOutEn,
  output logic ringerNegOut,
  output logic ringerNegOutEn
);

  // --------------------------------------------------------------------------
  // Pin synchronisers; a third stage feeds the edge detectors only
  // --------------------------------------------------------------------------
  logic [2:0] selSync_r;
  logic [2:0] sclSync_r;
  logic [1:0] sdiSync_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selSync_r <= 3'h7;
      sclSync_r <= 3'h0;
      sdiSync_r <= 2'h0;
    end else begin
      selSync_r <= {selSync_r[1:0], ctrlSelect_n};
      sclSync_r <= {sclSync_r[1:0], ctrlShiftClk};
      sdiSync_r <= {sdiSync_r[0], ctrlDataIn};
    end
  end

  wire selActive = !selSync_r[1];
  wire selRise = selSync_r[1] && !selSync_r[2];
  wire sclRise = sclSync_r[1] && !sclSync_r[2];
  wire sclFall = !sclSync_r[1] && sclSync_r[2];
  wire sdiBit = sdiSync_r[1];

  // --------------------------------------------------------------------------
  // Serial frame: 8 address bits then 8 data bits
  // --------------------------------------------------------------------------
  logic [4:0] bitCnt_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic sdo_r;
  logic sdoEn_r;
  logic [7:0] readData;

  wire inData = bitCnt_r >= 5'd8 && bitCnt_r < 5'd16;
  wire isRead = addr_r[`CCR_ADDR_READ_BIT];
  wire [4:0] regKey = {addr_r[`CCR_ADDR_BANK_BIT], addr_r[3:0]};
  wire [4:0] bitCntInc = bitCnt_r + 5'd1;
  wire writeDone = sclRise && selActive && !isRead && bitCnt_r == 5'd15;
  wire [7:0] writeValue = {wdata_r[6:0], sdiBit};
  wire [2:0] readIdx = 3'(5'd15 - bitCnt_r);

  // A select pause after the address byte keeps the count, so the data byte may follow later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_r <= 5'd0;
    end else if (selRise && bitCnt_r != 5'd8) begin
      bitCnt_r <= 5'd0;
    end else if (sclRise && selActive && bitCnt_r < 5'd16) begin
      bitCnt_r <= bitCntInc;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
    end else if (sclRise && selActive) begin
      if (bitCnt_r < 5'd8) begin
        addr_r <= {addr_r[6:0], sdiBit};
      end else begin
        wdata_r <= writeValue;
      end
    end
  end

  // Read data changes only on falling shift clock; pin floats before the data byte and whenever select is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo_r <= 1'b0;
      sdoEn_r <= 1'b0;
    end else if (!selActive) begin
      sdoEn_r <= 1'b0;
    end else if (sclFall && isRead && inData) begin
      sdo_r <= readData[readIdx];
      sdoEn_r <= 1'b1;
    end
  end

  assign ctrlDataOut = sdo_r;
  assign ctrlDataOutEn = sdoEn_r;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [7:0] digCtrl_r;
  logic [7:0] anaCtrl_r;
  logic [7:0] anaGain_r;
  logic [7:0] txGain_r;
  logic [7:0] sideGain_r;
  logic [7:0] rxGain_r;
  logic [7:0] toneCtl_r;
  logic [7:0] seqLow_r;
  logic [7:0] seqHigh_r;

  function automatic logic hits(input logic [4:0] key, input logic [4:0] target);
    hits = key == target;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      digCtrl_r <= `CCR_RST_DIGITAL_CONTROL;
      anaCtrl_r <= `CCR_RST_ANALOGUE_CONTROL;
      anaGain_r <= `CCR_RST_ANALOGUE_GAIN;
      txGain_r <= `CCR_RST_TX_DIGITAL_GAIN;
      sideGain_r <= `CCR_RST_SIDETONE_GAIN;
      rxGain_r <= `CCR_RST_RX_DIGITAL_GAIN;
      toneCtl_r <= `CCR_RST_TONE_CONTROL;
      seqLow_r <= `CCR_RST_SEQ_STEPS;
      seqHigh_r <= `CCR_RST_SEQ_STEPS;
    end else if (writeDone) begin
      if (hits(regKey, `CCR_KEY_DIGITAL_CONTROL)) begin
        digCtrl_r <= writeValue & `CCR_MASK_DIGITAL_CONTROL;
      end
      if (hits(regKey, `CCR_KEY_ANALOGUE_CONTROL)) begin
        anaCtrl_r <= writeValue & `CCR_MASK_ANALOGUE_CONTROL;
      end
      if (hits(regKey, `CCR_KEY_ANALOGUE_GAIN)) begin
        anaGain_r <= writeValue & `CCR_MASK_ANALOGUE_GAIN;
      end
      if (hits(regKey, `CCR_KEY_TX_DIGITAL_GAIN)) begin
        txGain_r <= writeValue;
      end
      if (hits(regKey, `CCR_KEY_SIDETONE_GAIN)) begin
        sideGain_r <= writeValue;
      end
      if (hits(regKey, `CCR_KEY_RX_DIGITAL_GAIN)) begin
        rxGain_r <= writeValue;
      end
      if (hits(regKey, `CCR_KEY_TONE_CONTROL)) begin
        toneCtl_r <= writeValue;
      end
      if (hits(regKey, `CCR_KEY_SEQ_STEPS_LOW)) begin
        seqLow_r <= writeValue & `CCR_MASK_SEQ_STEPS;
      end
      if (hits(regKey, `CCR_KEY_SEQ_STEPS_HIGH)) begin
        seqHigh_r <= writeValue & `CCR_MASK_SEQ_STEPS;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read selection; overload flags are live, unmapped locations read zero
  // --------------------------------------------------------------------------
  logic [7:0] statusBits;

  assign statusBits = {3'h0, rxOverload, txOverload, 3'h0};

  always_comb begin
    readData = 8'h00;
    if (hits(regKey, `CCR_KEY_DIGITAL_CONTROL)) readData = digCtrl_r;
    if (hits(regKey, `CCR_KEY_ANALOGUE_CONTROL)) readData = anaCtrl_r | statusBits;
    if (hits(regKey, `CCR_KEY_ANALOGUE_GAIN)) readData = anaGain_r;
    if (hits(regKey, `CCR_KEY_TX_DIGITAL_GAIN)) readData = txGain_r;
    if (hits(regKey, `CCR_KEY_SIDETONE_GAIN)) readData = sideGain_r;
    if (hits(regKey, `CCR_KEY_RX_DIGITAL_GAIN)) readData = rxGain_r;
    if (hits(regKey, `CCR_KEY_TONE_CONTROL)) readData = toneCtl_r;
    if (hits(regKey, `CCR_KEY_SEQ_STEPS_LOW)) readData = seqLow_r;
    if (hits(regKey, `CCR_KEY_SEQ_STEPS_HIGH)) readData = seqHigh_r;
  end

  // --------------------------------------------------------------------------
  // Codec controls
  // --------------------------------------------------------------------------
  wire rxEn = digCtrl_r[`CCR_DC_RXEN];
  wire txEn = digCtrl_r[`CCR_DC_TXEN];
  wire [3:0] divSel = digCtrl_r[`CCR_DC_DIV_HI:`CCR_DC_DIV_LO];

  assign codecCtrl.pcmALaw = digCtrl_r[`CCR_DC_ALAW];
  assign codecCtrl.pcmWordBits = digCtrl_r[`CCR_DC_ALAW] ? `CCR_PCM_ALAW_BITS : `CCR_PCM_LINEAR_BITS;
  assign codecCtrl.rxChannelOn = rxEn;
  assign codecCtrl.txChannelOn = txEn;
  assign codecCtrl.dividerOn = rxEn || txEn;
  assign codecCtrl.loopback = anaCtrl_r[`CCR_AC_LOOP];
  assign codecCtrl.earpieceOn = anaCtrl_r[`CCR_AC_EP];
  assign codecCtrl.speakerOn = anaCtrl_r[`CCR_AC_SPK];
  assign codecCtrl.voiceMute = anaCtrl_r[`CCR_AC_NOV];
  // The selected microphone is only powered while the transmit channel runs
  assign codecCtrl.micAConnect = txEn && anaGain_r[`CCR_AG_MICA];
  assign codecCtrl.micBConnect = txEn && anaGain_r[`CCR_AG_MICB];
  assign codecCtrl.micAmpGain = anaGain_r[`CCR_AG_MICGAIN_HI:`CCR_AG_MICGAIN_LO];
  assign codecCtrl.earpieceAmpGain = anaGain_r[`CCR_AG_EPGAIN_HI:`CCR_AG_EPGAIN_LO];
  assign codecCtrl.txDigitalGainCoeff = txGain_r;
  assign codecCtrl.sidetoneCoeff = sideGain_r;
  assign codecCtrl.sidetoneOn = sideGain_r != 8'h00;
  assign codecCtrl.rxDigitalGainCoeff = rxGain_r;

  // --------------------------------------------------------------------------
  // Master clock divider: one tick every divider value plus one cycles
  // --------------------------------------------------------------------------
  logic [3:0] divCnt_r;
  logic divTick_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 4'h0;
      divTick_r <= 1'b0;
    end else if (!codecCtrl.dividerOn) begin
      divCnt_r <= 4'h0;
      divTick_r <= 1'b0;
    end else if (divCnt_r >= divSel) begin
      divCnt_r <= 4'h0;
      divTick_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 4'h1;
      divTick_r <= 1'b0;
    end
  end

  assign dividedClkTick = divTick_r;

  // --------------------------------------------------------------------------
  // Cadence timebase: 1 ms or 4 ms steps
  // --------------------------------------------------------------------------
  wire slowStep = toneCtl_r[`CCR_TC_SLOW];
  wire startTone = toneCtl_r[`CCR_TC_START];
  logic [$clog2(MS_CYCLES)-1:0] msCnt_r;
  logic [2:0] msDiv_r;
  wire msTick = msCnt_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
  wire [2:0] stepMs = slowStep ? 3'(`CCR_CAD_STEP_SLOW_MS) : 3'(`CCR_CAD_STEP_FAST_MS);
  wire cadTick = msTick && msDiv_r == stepMs - 3'd1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_r <= '0;
      msDiv_r <= 3'd0;
    end else if (!startTone) begin
      msCnt_r <= '0;
      msDiv_r <= 3'd0;
    end else begin
      msCnt_r <= msTick ? '0 : msCnt_r + 1'b1;
      if (cadTick) begin
        msDiv_r <= 3'd0;
      end else if (msTick) begin
        msDiv_r <= msDiv_r + 3'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Six-step sequencer: each period is cadence period plus one steps long
  // --------------------------------------------------------------------------
  ccr_seq_state_t seqState_r;
  ccr_seq_state_t seqState_nxt;
  logic [7:0] cadCnt_r;
  logic [2:0] stepIdx_r;
  logic toneGate_r;

  wire periodEnd = cadTick && cadCnt_r == cadencePeriod;
  wire onEnd = cadTick && cadCnt_r + 8'd1 >= cadenceOnTime;
  wire lastStep = stepIdx_r == 3'd5;
  wire burstDone = toneCtl_r[`CCR_TC_BURST] && lastStep && periodEnd;
  wire [11:0] stepCodes = {seqHigh_r[5:0], seqLow_r[5:0]};
  wire [2:0] stepIdxNxt = seqState_nxt == SEQ_IDLE ? 3'd0 :
    periodEnd ? (lastStep ? 3'd0 : stepIdx_r + 3'd1) : stepIdx_r;
  wire [1:0] stepCode = stepCodes[{stepIdx_r, 1'b0} +: 2];
  // Gate follows the step about to play, so a silent step never inherits the previous tone
  wire [1:0] stepCodeNxt = stepCodes[{stepIdxNxt, 1'b0} +: 2];

  always_comb begin
    seqState_nxt = seqState_r;
    unique case (seqState_r)
      SEQ_IDLE: if (startTone) seqState_nxt = SEQ_ON;
      SEQ_ON: begin
        if (!startTone || burstDone) seqState_nxt = SEQ_IDLE;
        else if (periodEnd) seqState_nxt = SEQ_ON;
        else if (onEnd) seqState_nxt = SEQ_OFF;
      end
      SEQ_OFF: begin
        if (!startTone || burstDone) seqState_nxt = SEQ_IDLE;
        else if (periodEnd) seqState_nxt = SEQ_ON;
      end
      default: seqState_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seqState_r <= SEQ_IDLE;
      cadCnt_r <= 8'h00;
      stepIdx_r <= 3'd0;
      toneGate_r <= 1'b0;
    end else begin
      seqState_r <= seqState_nxt;
      toneGate_r <= seqState_nxt == SEQ_ON && cadenceOnTime != 8'h00 && stepCodeNxt != 2'b00;
      stepIdx_r <= stepIdxNxt;
      if (seqState_nxt == SEQ_IDLE) begin
        cadCnt_r <= 8'h00;
      end else if (periodEnd) begin
        cadCnt_r <= 8'h00;
      end else if (cadTick) begin
        cadCnt_r <= cadCnt_r + 8'd1;
      end
    end
  end

  assign toneCtrl.rxInject = toneCtl_r[`CCR_TC_RX_TONE_INJECT];
  assign toneCtrl.txInject = toneCtl_r[`CCR_TC_TX_TONE_INJECT];
  assign toneCtrl.squareWave = toneCtl_r[`CCR_TC_SQUARE];
  assign toneCtrl.dualTone = toneCtl_r[`CCR_TC_DUAL];
  assign toneCtrl.burst = toneCtl_r[`CCR_TC_BURST];
  assign toneCtrl.running = seqState_r != SEQ_IDLE;
  assign toneCtrl.gate = toneGate_r;
  assign toneCtrl.stepCode = stepCode;
  assign toneCtrl.stepIndex = stepIdx_r;

  // --------------------------------------------------------------------------
  // Tone ringer push/pull pins; both float while ringer inject is low
  // --------------------------------------------------------------------------
  logic ringPos_r;
  logic ringEn_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ringPos_r <= 1'b0;
      ringEn_r <= 1'b0;
    end else begin
      ringPos_r <= toneWave && toneGate_r;
      ringEn_r <= toneCtl_r[`CCR_TC_RING];
    end
  end

  // Negative pin is the complement while the tone gate is high, so the pair swings differentially
  assign ringerPosOut = ringPos_r;
  assign ringerNegOut = !ringPos_r && toneGate_r;
  assign ringerPosOutEn = ringEn_r;
  assign ringerNegOutEn = ringEn_r;

endmodule

// [tb/ccr_host_model.sv]
// Host controller on the serial control port.
// Assumes four-clock shift clock phases, well above the sampling minimum.
`timescale 1ns/1ps
module ccr_host_model (
  // Clock
  input wire logic clock,
  // Serial control port
  output logic ctrlSelect_n,
  output logic ctrlShiftClk,
  output logic ctrlDataIn,
  input wire logic ctrlDataOut
);
  initial begin
    ctrlSelect_n = 1'b1;
    ctrlShiftClk = 1'b0;
    ctrlDataIn = 1'b0;
  end
  // Address byte then data byte, MSB first; read bits taken late in the high phase
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {addr, wdata};
    @(posedge clock) ctrlSelect_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 15; i >= 0; i--) begin
      ctrlShiftClk <= 1'b0;
      ctrlDataIn <= frame[i];
      repeat (4) @(posedge clock);
      ctrlShiftClk <= 1'b1;
      repeat (4) @(posedge clock);
      if (i < 8) rdata[i] = ctrlDataOut;
    end
    ctrlSelect_n <= 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    ctrlDataIn <= ~frame[0];
    repeat (4) @(posedge clock);
    ctrlShiftClk <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
endmodule

// [tb/ccr_register_bank_properties.sv]
// Port checks for the codec control register bank.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module ccr_register_bank_properties
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Observed ports
  input wire logic ctrlSelect_n,
  input wire logic ctrlDataOutEn,
  input wire logic dividedClkTick,
  input wire ccr_ctrl_t codecCtrl,
  input wire ccr_tone_t toneCtrl,
  input wire logic ringerPosOut,
  input wire logic ringerPosOutEn,
  input wire logic ringerNegOut,
  input wire logic ringerNegOutEn
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pcm_word_len: assert property (
    codecCtrl.pcmWordBits == (codecCtrl.pcmALaw ? 5'd8 : 5'd16)) else $error("pcm word length wrong");
  a_divider_power: assert property (
    codecCtrl.dividerOn == (codecCtrl.rxChannelOn | codecCtrl.txChannelOn)) else $error("divider power wrong");
  a_tick_idle: assert property (
    !codecCtrl.dividerOn [*2] |-> !dividedClkTick) else $error("divider ticks while off");
  a_mic_gating: assert property (
    (codecCtrl.micAConnect | codecCtrl.micBConnect) |-> codecCtrl.txChannelOn) else $error("mic without tx");
  a_sidetone_off: assert property (
    codecCtrl.sidetoneOn == (codecCtrl.sidetoneCoeff != 8'h00)) else $error("sidetone enable wrong");
  a_ringer_pair: assert property (
    ringerPosOutEn == ringerNegOutEn) else $error("ringer enables differ");
  a_ringer_excl: assert property (
    ringerNegOut |-> !ringerPosOut) else $error("ringer pins both high");
  a_ringer_quiet: assert property (
    ringerPosOut |-> $past(toneCtrl.gate)) else $error("ringer driven without tone gate");
  a_tone_stop: assert property (
    !toneCtrl.running [*2] |-> !toneCtrl.gate) else $error("gate while stopped");
  a_step_range: assert property (
    toneCtrl.stepIndex <= 3'd5) else $error("step index beyond six");
  a_port_release: assert property (
    ctrlSelect_n [*6] |-> !ctrlDataOutEn) else $error("data out driven while deselected");
endmodule

bind ccr_register_bank ccr_register_bank_properties ccr_register_bank_properties_i (
  .clock(clock), .rst_n(rst_n), .ctrlSelect_n(ctrlSelect_n), .ctrlDataOutEn(ctrlDataOutEn),
  .dividedClkTick(dividedClkTick), .codecCtrl(codecCtrl), .toneCtrl(toneCtrl),
  .ringerPosOut(ringerPosOut), .ringerPosOutEn(ringerPosOutEn),
  .ringerNegOut(ringerNegOut), .ringerNegOutEn(ringerNegOutEn));

// [tb/tb_ccr_register_bank.sv]
// Testbench of the codec control register bank.
// Assumes the host model drives the serial port; short cadence steps.
`timescale 1ns/1ps
module tb_ccr_register_bank import ccr_pkg::*;;
  logic clock, rst_n, sel_n, scl, sdi, sdo, sdoEn, rxOverload, txOverload, toneWave, tick;
  logic [7:0] cadencePeriod, cadenceOnTime;
  logic ringP, ringPEn, ringN, ringNEn;
  ccr_ctrl_t codecCtrl;
  ccr_tone_t toneCtrl;
  int failures = 0, checkCount = 0, cycleCount = 0, ticks = 0;
  logic [4:0] keys [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h10, 5'h11, 5'h12};
  logic [7:0] rstv [9] = '{8'h00, 8'h00, 8'h08, 8'h6d, 8'h20, 8'h5b, 8'h00, 8'h00, 8'h00};
  logic [7:0] masks [9] = '{8'hfe, 8'h27, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f};

  ccr_register_bank #(.MS_CYCLES(4)) ccr_register_bank_i (
    .clock(clock), .rst_n(rst_n), .ctrlSelect_n(sel_n), .ctrlShiftClk(scl), .ctrlDataIn(sdi),
    .ctrlDataOut(sdo), .ctrlDataOutEn(sdoEn), .rxOverload(rxOverload), .txOverload(txOverload),
    .cadencePeriod(cadencePeriod), .cadenceOnTime(cadenceOnTime), .toneWave(toneWave),
    .dividedClkTick(tick), .codecCtrl(codecCtrl), .toneCtrl(toneCtrl), .ringerPosOut(ringP),
    .ringerPosOutEn(ringPEn), .ringerNegOut(ringN), .ringerNegOutEn(ringNEn));
  ccr_host_model host_i (.clock(clock), .ctrlSelect_n(sel_n), .ctrlShiftClk(scl), .ctrlDataIn(sdi),
    .ctrlDataOut(sdoEn ? sdo : ~sdo));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    toneWave <= ~toneWave;
    cycleCount++;
    // About 40 frames of some 150 cycles each fit well inside this ceiling
    if (cycleCount == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] key, input logic [7:0] d);
    logic [7:0] q;
    host_i.xfer({3'b000, key}, d, q);
  endtask
  task automatic rd(input logic [4:0] key, input logic [7:0] exp);
    logic [7:0] q;
    host_i.xfer({3'b100, key}, 8'h00, q);
    check($sformatf("register %h", key), exp, q);
  endtask

  initial begin
    rst_n = 1'b0;
    rxOverload = 1'b0;
    txOverload = 1'b0;
    toneWave = 1'b0;
    cadencePeriod = 8'h03;
    cadenceOnTime = 8'h01;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (keys[i]) rd(keys[i], rstv[i]);
    foreach (keys[i]) begin
      wr(keys[i], 8'hff);
      rd(keys[i], masks[i]);
    end
    check("word bits", 8'd8, 8'(codecCtrl.pcmWordBits));
    check("mic b", 8'h01, 8'(codecCtrl.micBConnect));
    check("ringer enable", 8'h03, 8'({ringPEn, ringNEn}));
    check("tone modes", 8'h1f, 8'({toneCtrl.rxInject, toneCtrl.txInject, toneCtrl.squareWave,
      toneCtrl.dualTone, toneCtrl.burst}));
    check("voice ctrls", 8'h3f, 8'({codecCtrl.loopback, codecCtrl.earpieceOn, codecCtrl.speakerOn,
      codecCtrl.voiceMute, codecCtrl.micAConnect, codecCtrl.micBConnect}));
    check("amp gains", 8'h1f, 8'({codecCtrl.micAmpGain, codecCtrl.earpieceAmpGain}));
    check("tx gain coeff", 8'hff, codecCtrl.txDigitalGainCoeff);
    check("rx gain coeff", 8'hff, codecCtrl.rxDigitalGainCoeff);
    check("channels on", 8'h03, 8'({codecCtrl.rxChannelOn, codecCtrl.txChannelOn}));
    wr(5'h04, 8'h5a);
    rd(5'h04, 8'h00);
    rxOverload <= 1'b1;
    rd(5'h01, 8'h37);
    rxOverload <= 1'b0;
    txOverload <= 1'b1;
    rd(5'h01, 8'h2f);
    txOverload <= 1'b0;
    wr(5'h05, 8'h00);
    check("sidetone on", 8'h00, 8'(codecCtrl.sidetoneOn));
    wr(5'h00, 8'h44);
    ticks = 0;
    repeat (30) begin
      @(negedge clock);
      if (tick === 1'b1) ticks++;
    end
    check("divide by three ticks", 8'd10, 8'(ticks));
    check("linear bits", 8'd16, 8'(codecCtrl.pcmWordBits));
    wr(5'h00, 8'h00);
    check("divider on", 8'h00, 8'(codecCtrl.dividerOn));
    wr(5'h10, 8'h00);
    wr(5'h11, 8'h01);
    // Only the first step sounds, so any gated cycle must show step one
    wr(5'h12, 8'h00);
    wr(5'h10, 8'h81);
    for (int i = 0; i < 300 && toneCtrl.gate !== 1'b1; i++) @(negedge clock);
    check("tone gate", 8'h01, 8'(toneCtrl.gate));
    check("step code", 8'h01, 8'(toneCtrl.stepCode));
    check("step index", 8'h00, 8'(toneCtrl.stepIndex));
    wr(5'h10, 8'h00);
    check("running", 8'h00, 8'(toneCtrl.running));
    check("ringer float", 8'h00, 8'({ringPEn, ringNEn}));
    check("ringer pins", 8'h00, 8'({ringP, ringN}));
    print_verdict();
  end
endmodule
